// ### seq_ctrl_model.sv
// sequence controller stand-in that watches the reporter's warning outputs
// assumes registered reporter outputs on the same clock
module seq_ctrl_model (
  // clock
  input wire logic ref_clk,
  // reporter outputs
  input wire logic [8:0] spindle_warning_code,
  input wire logic spindle_alarm,
  // reaction
  output logic retract_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // spindle keeps running, so back off before the alarm lands
  always @(posedge ref_clk) begin
    retract_req <= (spindle_warning_code != 9'h000) && !spindle_alarm;
  end
endmodule // seq_ctrl_model

// ### spindle_warn_map.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the design module and the bench only
`ifndef SPINDLE_WARN_MAP_SVH
`define SPINDLE_WARN_MAP_SVH
`define OFF_WARN_LOW 4'h0
`define OFF_WARN_HIGH 4'h1
`define OFF_ID_CFG 4'h2
`define OFF_IRQ_STATUS 4'h3
`define OFF_IRQ_MASK 4'h4
`define OFF_ID_CMD 4'h5
`define OFF_ID_MISMATCH 4'h6
`define OFF_DIAG_WARN0 4'h8
`define OFF_DIAG_ERR0 4'hC
`define BIT_ID_EDIT 0
`define BIT_ID_HIDE 2
`define CFG_RESET 8'h00
`define CODE_INT_FAN 9'h038
`define CODE_RAD_FAN 9'h058
`define CODE_OPEN_PHASE 9'h004
`define CODE_CONV_OVLD 9'h03A
`define CODE_CONV_FAN 9'h03B
`define CODE_CONV_RAD 9'h071
`define ONE_MIN_MS 60000
`define FIVE_SEC_MS 5000
`define CLK_MHZ 250
`define ID_ITEMS 12
`endif

// ### spindle_warn_pkg.sv
// types shared by the warning reporter
// assumes the map header for constants
package spindle_warn_pkg;
  typedef struct packed {
    logic [3:0] newer_gen;
    logic [3:0] older_gen;
    logic regen_supply;
  } spindle_cfg_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef enum logic [3:0] {
    ID_IDLE = 4'b0001,
    ID_CAPTURE = 4'b0010,
    ID_COMPARE = 4'b0100,
    ID_DONE = 4'b1000
  } id_state_t;
endpackage

// ### spindle_warning_status_reporter.sv
// spindle warning code reporter, diagnostics, id record check
// assumes amplifier status inputs are asynchronous and id records are parallel
//
// Contract
// - a warning from a qualifying spindle appears as nine-bit code.
// - code bits one to eight in low byte, bit nine at high byte bit 0.
// - simultaneous warnings: lowest axis number wins.
// - function disabled without newer spindles or with any older spindle.
// - codes 56,88,04,58,59,113 name the documented causes.
// - 56,58,59 and 04 raise alarm after one minute, 04 regen five seconds.
// - radiator fan warnings raise alarm only on real overheat.
// - per-spindle warning numbers, zero when none.
// - per-spindle error numbers, zero when none.
// - any older amplifier suppresses all error numbers.
// - first startup stores identification records in nonvolatile memory.
// - later startups flag each differing record item as mismatched.
// - config bit 0 allows record editing when one.
// - config bit 2 hides identification display when one.
// - edited records stay flagged when differing from units read.
//
// The placing of the registers and strobed register access were chosen for this implementation.
`include "spindle_warn_map.svh"
module spindle_warning_status_reporter
  import spindle_warn_pkg::*;
#(
  // one minute at full clock rate needs more than 32 bits
  parameter longint ONE_MIN_CYC = longint'(`ONE_MIN_MS) * 1000 * `CLK_MHZ,
  parameter longint FIVE_SEC_CYC = longint'(`FIVE_SEC_MS) * 1000 * `CLK_MHZ
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // amplifier status, asynchronous
  input wire logic [35:0] amp_warn_num,
  input wire logic [35:0] amp_err_num,
  input wire logic [3:0] amp_overheat,
  input wire spindle_cfg_t amp_cfg,
  // identification records
  input wire logic [`ID_ITEMS*8-1:0] id_read_data,
  input wire logic id_first_start,
  input wire logic id_start,
  // outputs
  output logic [8:0] spindle_warning_code,
  output logic spindle_alarm,
  output logic id_screen_show,
  output logic irq
);
  localparam int NI = `ID_ITEMS;
  function automatic logic [8:0] lane(input logic [35:0] v, input int i);
    return v[i*9 +: 9];
  endfunction
  function automatic logic timed_code(input logic [8:0] c);
    return c == `CODE_INT_FAN || c == `CODE_CONV_OVLD || c == `CODE_CONV_FAN ||
      c == `CODE_OPEN_PHASE;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic rst_s1_reg, rst_n;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // two-stage sync of every asynchronous input
  localparam int SW = 36 + 36 + 4 + 9 + NI * 8 + 2;
  logic [SW-1:0] sync1_reg, sync2_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {amp_warn_num, amp_err_num, amp_overheat, amp_cfg, id_read_data,
        id_first_start, id_start};
      sync2_reg <= sync1_reg;
    end
  end
  logic [35:0] warn_s, err_s;
  logic [3:0] heat_s;
  spindle_cfg_t cfg_s;
  logic [NI*8-1:0] idr_s;
  logic first_s, start_s;
  assign {warn_s, err_s, heat_s, cfg_s, idr_s, first_s, start_s} = sync2_reg;

  ////////////////////////////////////////////////////////////////////////
  // warning arbitration
  logic func_en;
  logic [8:0] code_next, code_reg;
  logic [35:0] diag_warn_reg, diag_err_reg;
  assign func_en = (|cfg_s.newer_gen) && !(|cfg_s.older_gen);
  always_comb begin
    code_next = 9'h000;
    for (int i = 3; i >= 0; i--) begin
      if (cfg_s.newer_gen[i] && lane(warn_s, i) != 9'h000) begin
        code_next = lane(warn_s, i);
      end
    end
    if (!func_en) begin
      code_next = 9'h000;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_reg <= 9'h000;
      spindle_warning_code <= 9'h000;
    end else begin
      code_reg <= code_next;
      spindle_warning_code <= code_next;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_warn_reg <= '0;
      diag_err_reg <= '0;
    end else begin
      diag_warn_reg <= warn_s;
      diag_err_reg <= (|cfg_s.older_gen) ? 36'h0 : err_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alarm timing; controller gets the warning first to react
  logic [35:0] alarm_cnt_reg;
  logic [35:0] limit;
  assign limit = (code_reg == `CODE_OPEN_PHASE && cfg_s.regen_supply) ?
    36'(FIVE_SEC_CYC) : 36'(ONE_MIN_CYC);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_cnt_reg <= '0;
      spindle_alarm <= 1'b0;
    end else begin
      if (code_reg != code_next || !timed_code(code_reg)) begin
        alarm_cnt_reg <= '0;
      end else if (alarm_cnt_reg < limit) begin
        alarm_cnt_reg <= alarm_cnt_reg + 36'h1;
      end
      spindle_alarm <= (timed_code(code_reg) && alarm_cnt_reg >= limit) ||
        (func_en && |(heat_s & cfg_s.newer_gen));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // identification records
  logic [7:0] cfg_reg;
  logic [7:0] store_mem [NI];
  logic [7:0] buf_reg;
  logic [3:0] sel_reg;
  logic [NI-1:0] mismatch_reg;
  logic [NI-1:0] mismatch_next;
  id_state_t id_state_reg;
  logic start_d_reg;
  logic edit_ok;
  assign edit_ok = cfg_reg[`BIT_ID_EDIT];
  always_comb begin
    for (int k = 0; k < NI; k++) begin
      mismatch_next[k] = store_mem[k] != idr_s[k*8 +: 8];
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      id_state_reg <= ID_IDLE;
      start_d_reg <= 1'b0;
      mismatch_reg <= '0;
    end else begin
      start_d_reg <= start_s;
      case (id_state_reg)
        ID_IDLE: begin
          if (start_s && !start_d_reg) begin
            id_state_reg <= first_s ? ID_CAPTURE : ID_COMPARE;
          end
        end
        ID_CAPTURE: id_state_reg <= ID_DONE;
        ID_COMPARE: begin
          mismatch_reg <= mismatch_next;
          id_state_reg <= ID_DONE;
        end
        ID_DONE: begin
          mismatch_reg <= mismatch_next;
          if (start_s && !start_d_reg) begin
            id_state_reg <= first_s ? ID_CAPTURE : ID_COMPARE;
          end
        end
        default: id_state_reg <= ID_IDLE;
      endcase
    end
  end
  // command byte: [3:0] item, [4] copy, [5] write, [6] save
  logic cmd_wr;
  assign cmd_wr = reg_wr && reg_addr == `OFF_ID_CMD && edit_ok;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_reg <= 8'h00;
      sel_reg <= 4'h0;
    end else if (cmd_wr) begin
      sel_reg <= reg_wdata[3:0];
      if (reg_wdata[4]) begin
        buf_reg <= idr_s[reg_wdata[3:0]*8 +: 8];
      end
    end
  end
  // store_mem stands in for the nonvolatile copy; no reset so it maps to ram
  always_ff @(posedge ref_clk) begin
    if (id_state_reg == ID_CAPTURE) begin
      for (int k = 0; k < NI; k++) begin
        store_mem[k] <= idr_s[k*8 +: 8];
      end
    end else if (cmd_wr && reg_wdata[5] && reg_wdata[3:0] < 4'(NI)) begin
      store_mem[reg_wdata[3:0]] <= buf_reg;
    end
  end
  logic save_done_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      save_done_reg <= 1'b0;
    end else begin
      save_done_reg <= cmd_wr && reg_wdata[6];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers and interrupt; bit0 warning, bit1 alarm, bit2 mismatch
  logic [7:0] irq_stat_reg, irq_mask_reg;
  logic [2:0] ev;
  assign ev = {|(mismatch_next & ~mismatch_reg) && id_state_reg == ID_DONE,
    spindle_alarm, code_next != 9'h000 && code_reg == 9'h000};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= `CFG_RESET;
      irq_mask_reg <= 8'h00;
      irq_stat_reg <= 8'h00;
      id_screen_show <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `OFF_ID_CFG) cfg_reg <= reg_wdata;
      if (reg_wr && reg_addr == `OFF_IRQ_MASK) irq_mask_reg <= reg_wdata;
      // set wins over write-one-to-clear
      irq_stat_reg <= (irq_stat_reg &
        ~((reg_wr && reg_addr == `OFF_IRQ_STATUS) ? reg_wdata : 8'h00)) | {5'h00, ev};
      id_screen_show <= !cfg_reg[`BIT_ID_HIDE];
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFF_WARN_LOW: reg_rdata <= code_reg[7:0];
        `OFF_WARN_HIGH: reg_rdata <= {7'h00, code_reg[8]};
        `OFF_ID_CFG: reg_rdata <= cfg_reg;
        `OFF_IRQ_STATUS: reg_rdata <= irq_stat_reg;
        `OFF_IRQ_MASK: reg_rdata <= irq_mask_reg;
        `OFF_ID_CMD: reg_rdata <= {save_done_reg, 3'h0, sel_reg};
        `OFF_ID_MISMATCH: reg_rdata <= mismatch_reg[7:0];
        4'h7: reg_rdata <= {4'h0, mismatch_reg[NI-1:8]};
        4'h8, 4'h9, 4'hA, 4'hB: reg_rdata <= diag_warn_reg[int'(reg_addr[1:0]) * 9 +: 8];
        4'hC, 4'hD, 4'hE, 4'hF: reg_rdata <= diag_err_reg[int'(reg_addr[1:0]) * 9 +: 8];
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  sequence s_disabled;
    !func_en;
  endsequence
  a_disable_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_disabled |=> spindle_warning_code == 9'h000) else $error("code not zero");
  a_code_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> spindle_warning_code == $past(code_next)) else $error("code lag");
  a_lowest_axis: assert property (@(posedge ref_clk) disable iff (!rst_n)
    func_en && cfg_s.newer_gen[0] && lane(warn_s, 0) != 9'h000
    |=> spindle_warning_code == $past(lane(warn_s, 0))) else $error("arb");
  a_err_suppress: assert property (@(posedge ref_clk) disable iff (!rst_n)
    |cfg_s.older_gen |=> diag_err_reg == 36'h0) else $error("err shown");
  a_no_timed_rad: assert property (@(posedge ref_clk) disable iff (!rst_n)
    code_reg == `CODE_RAD_FAN |=> alarm_cnt_reg == 36'h0) else $error("timed");
  a_edit_lock: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !edit_ok && reg_wr && reg_addr == `OFF_ID_CMD
    |=> $stable(sel_reg) && $stable(buf_reg)) else $error("edit");
  a_hide_screen: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg_reg[`BIT_ID_HIDE] |=> !id_screen_show) else $error("shown");
  a_compare_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    id_state_reg == ID_COMPARE |=> mismatch_reg == $past(mismatch_next)) else $error("mm");
  a_high_byte: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `OFF_WARN_HIGH |=> reg_rdata[7:1] == 7'h00) else $error("hb");
endmodule // spindle_warning_status_reporter

// ### spindle_warning_status_reporter_bench.sv
// self-checking bench for the spindle warning reporter
// assumes the package, map header and design are compiled first
`include "spindle_warn_map.svh"
module spindle_warning_status_reporter_bench;
  import spindle_warn_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic [3:0] reg_addr = 4'h0, amp_overheat = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [35:0] amp_warn_num = 36'h0, amp_err_num = 36'h0;
  spindle_cfg_t amp_cfg = '0;
  logic [95:0] id_read_data = '0;
  logic id_first_start = 1'b0, id_start = 1'b0;
  logic [8:0] spindle_warning_code;
  logic spindle_alarm, id_screen_show, irq, retract_req;
  logic [7:0] exp_q[$];
  logic [8:0] codes[7];
  int miscompares = 0, checked = 0;
  always #2 ref_clk = ~ref_clk;
  // short counts keep the timed alarms inside the run
  spindle_warning_status_reporter #(.ONE_MIN_CYC(100), .FIVE_SEC_CYC(20))
    i_spindle_warning_status_reporter (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .amp_warn_num, .amp_err_num, .amp_overheat, .amp_cfg,
    .id_read_data, .id_first_start, .id_start, .spindle_warning_code, .spindle_alarm,
    .id_screen_show, .irq);
  seq_ctrl_model i_seq_ctrl_model (.ref_clk, .spindle_warning_code, .spindle_alarm,
    .retract_req);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [8:0] exp, input logic [8:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  // inputs pass two sync flops, so give them room before looking
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic set_warn(input logic [35:0] w);
    @(posedge ref_clk);
    amp_warn_num <= w;
    settle(5);
  endtask
  task automatic pulse_start;
    @(posedge ref_clk);
    id_start <= 1'b1;
    repeat (4) @(posedge ref_clk);
    id_start <= 1'b0;
    settle(40);
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_d) cmp({1'b0, exp_q.pop_front()}, {1'b0, reg_rdata});
    rd_d <= reg_rd;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h9903d71c));
    codes = '{`CODE_INT_FAN, `CODE_RAD_FAN, `CODE_OPEN_PHASE, `CODE_CONV_OVLD,
      `CODE_CONV_FAN, `CODE_CONV_RAD, 9'h100 | 9'($urandom)};
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(`OFF_ID_CFG, `CFG_RESET);
    settle(2);
    cmp(9'h000, spindle_warning_code);
    cmp(9'h001, {8'h00, id_screen_show});
    amp_cfg <= 9'h1E0;
    foreach (codes[k]) begin
      set_warn({27'h0, codes[k]});
      cmp(codes[k], spindle_warning_code);
      rd(`OFF_WARN_LOW, codes[k][7:0]);
      rd(`OFF_WARN_HIGH, {7'h00, codes[k][8]});
    end
    amp_err_num <= {9'h011, 9'h022, 9'h033, 9'h144};
    set_warn({9'h000, 9'h003, 9'h0AA, 9'h000});
    cmp(9'h0AA, spindle_warning_code);
    for (int k = 0; k < 4; k++) begin
      rd(4'(`OFF_DIAG_WARN0 + k), amp_warn_num[9*k +: 8]);
      rd(4'(`OFF_DIAG_ERR0 + k), amp_err_num[9*k +: 8]);
    end
    amp_cfg <= 9'h180;
    settle(5);
    cmp(9'h003, spindle_warning_code);
    amp_cfg <= 9'h1E2;
    settle(5);
    cmp(9'h000, spindle_warning_code);
    rd(`OFF_DIAG_ERR0, 8'h00);
    amp_cfg <= 9'h000;
    settle(5);
    cmp(9'h000, spindle_warning_code);
    amp_cfg <= 9'h1E0;
    set_warn(36'h0);
    wr(`OFF_IRQ_STATUS, 8'hFF);
    wr(`OFF_IRQ_MASK, 8'h01);
    settle(3);
    cmp(9'h000, {8'h00, irq});
    set_warn({27'h0, `CODE_RAD_FAN});
    cmp(9'h001, {8'h00, irq});
    cmp(9'h001, {8'h00, retract_req});
    wr(`OFF_IRQ_MASK, 8'h00);
    settle(3);
    cmp(9'h000, {8'h00, irq});
    wr(`OFF_IRQ_MASK, 8'h01);
    wr(`OFF_IRQ_STATUS, 8'h01);
    settle(150);
    cmp(9'h000, {8'h00, irq});
    cmp(9'h000, {8'h00, spindle_alarm});
    amp_overheat <= 4'h1;
    settle(6);
    cmp(9'h001, {8'h00, spindle_alarm});
    amp_overheat <= 4'h0;
    set_warn(36'h0);
    set_warn({27'h0, `CODE_OPEN_PHASE});
    settle(40);
    cmp(9'h000, {8'h00, spindle_alarm});
    settle(70);
    cmp(9'h001, {8'h00, spindle_alarm});
    amp_cfg <= 9'h1E1;
    set_warn(36'h0);
    set_warn({27'h0, `CODE_INT_FAN});
    settle(30);
    cmp(9'h000, {8'h00, spindle_alarm});
    set_warn(36'h0);
    set_warn({27'h0, `CODE_OPEN_PHASE});
    settle(30);
    cmp(9'h001, {8'h00, spindle_alarm});
    wr(`OFF_ID_CFG, 8'h04);
    settle(5);
    cmp(9'h000, {8'h00, id_screen_show});
    id_read_data <= {$urandom, $urandom, $urandom};
    id_first_start <= 1'b1;
    pulse_start;
    id_first_start <= 1'b0;
    id_read_data[31:24] <= ~id_read_data[31:24];
    pulse_start;
    rd(`OFF_ID_MISMATCH, 8'h08);
    rd(`OFF_ID_MISMATCH + 4'h1, 8'h00);
    // commands while editing is barred must leave the record alone
    wr(`OFF_ID_CMD, 8'h13);
    wr(`OFF_ID_CMD, 8'h23);
    wr(`OFF_ID_CMD, 8'h43);
    settle(5);
    rd(`OFF_ID_MISMATCH, 8'h08);
    wr(`OFF_ID_CFG, 8'h01);
    settle(5);
    cmp(9'h001, {8'h00, id_screen_show});
    wr(`OFF_ID_CMD, 8'h13);
    wr(`OFF_ID_CMD, 8'h23);
    wr(`OFF_ID_CMD, 8'h43);
    settle(5);
    rd(`OFF_ID_MISMATCH, 8'h00);
    settle(3);
    complete_run;
  end
  // whole sequence needs about six hundred fifty cycles
  initial begin
    repeat (6000) @(posedge ref_clk);
    miscompares++;
    complete_run;
  end
endmodule // spindle_warning_status_reporter_bench
